/* hw/crc16_step.sv */
`timescale 1ns/1ns
`default_nettype none

// one whole byte through the reflected checksum, eight shifts
module crc16_step (
    // running value
    input wire logic [15:0] crc_in,
    // byte to fold in
    input wire logic [7:0] data,
    output logic [15:0] crc_out
);

    // xor the byte in, then shift right and fold the polynomial on overflow
    always_comb begin
        crc_out = crc_in ^ {8'h00, data};
        for (int i = 0; i < msg_pkg::CRC_BITS; i++) begin
            if (crc_out[0]) begin
                crc_out = (crc_out >> 1) ^ msg_pkg::CRC_POLY;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end

endmodule : crc16_step
`default_nettype wire

/* hw/msg_handler.sv */
`timescale 1ns/1ns
`default_nettype none

//Contract
// - Function 03H reads up to 16 consecutive registers from the start address.
// - Function 08H echoes the command frame byte for byte.
// - Function 10H writes supplied words to successive registers from start.
// - Every data word travels high byte first, low byte second.
// - Register space splits into command, monitor and broadcast data.
// - Checksum: preset FFFFH, bytewise right shifts, xor A001H, from address.
// - Address 0 is broadcast: acted on, never answered; only function 10H writes are carried out, 03H and 08H are dropped.
// - Every register is exactly one two-byte word.
module msg_handler (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // own station address
    input wire logic [7:0] station_addr,
    // received byte stream from the serial framer
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic rx_frame_end,
    // transmitted byte stream to the serial framer
    output logic [7:0] tx_byte_r,
    output logic tx_valid_r,
    input wire logic tx_ready,
    // register table access
    output msg_pkg::reg_req_t reg_req_r,
    input wire logic [15:0] reg_rdata,
    // status
    output logic busy_r
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RECV, ST_CHECK, ST_READ, ST_READ_WAIT, ST_READ_CAP, ST_WRITE, ST_SEND
    } state_t;

    state_t state_r, state_nxt;
    logic [7:0] rxb_r [msg_pkg::RX_MAX];
    logic [7:0] rxb_nxt [msg_pkg::RX_MAX];
    logic [7:0] txb_r [msg_pkg::TX_MAX];
    logic [7:0] txb_nxt [msg_pkg::TX_MAX];
    logic [5:0] rx_cnt_r, rx_cnt_nxt;
    logic rx_ovf_r, rx_ovf_nxt;
    logic [15:0] rx_crc_r, rx_crc_nxt, rx_crc_step;
    logic [15:0] tx_crc_r, tx_crc_nxt, tx_crc_step;
    logic [5:0] tx_len_r, tx_len_nxt;
    logic [5:0] tx_idx_r, tx_idx_nxt;
    logic [4:0] idx_r, idx_nxt;
    logic no_reply_r, no_reply_nxt;
    logic [7:0] tx_byte_nxt;
    logic tx_valid_nxt;
    msg_pkg::reg_req_t reg_req_nxt;
    logic busy_nxt;

    // request fields decoded from the buffer
    logic [15:0] start_addr, qty, last_addr, cur_addr;
    logic [7:0] func, load_byte;
    logic bcast, qty_ok, ro_hit;

    assign func = rxb_r[msg_pkg::POS_FUNC];
    assign start_addr = {rxb_r[msg_pkg::POS_START_HI], rxb_r[msg_pkg::POS_START_LO]};
    assign qty = {rxb_r[msg_pkg::POS_QTY_HI], rxb_r[msg_pkg::POS_QTY_LO]};
    assign last_addr = start_addr + qty - 16'h0001;
    assign cur_addr = start_addr + {11'h000, idx_r};
    assign bcast = (rxb_r[msg_pkg::POS_ADDR] == msg_pkg::BCAST_ADDR);
    assign qty_ok = (qty != 16'h0000) && (qty <= 16'(msg_pkg::MAX_REGS));
    // monitor data cannot be written
    assign ro_hit = (start_addr < msg_pkg::BCAST_BASE) && (last_addr >= msg_pkg::MONITOR_BASE);
    assign load_byte = txb_r[tx_idx_r];

    // checksum steppers for the receive and transmit streams
    crc16_step u_rx_crc (
        .crc_in(rx_crc_r),
        .data(rx_byte),
        .crc_out(rx_crc_step)
    );

    crc16_step u_tx_crc (
        .crc_in(tx_crc_r),
        .data(load_byte),
        .crc_out(tx_crc_step)
    );

    // map a register address to its data category
    function automatic msg_pkg::reg_cat_t cat_of(input logic [15:0] a);
        if (a >= msg_pkg::BCAST_BASE) begin
            cat_of = msg_pkg::CAT_BROADCAST;
        end else if (a >= msg_pkg::MONITOR_BASE) begin
            cat_of = msg_pkg::CAT_MONITOR;
        end else begin
            cat_of = msg_pkg::CAT_COMMAND;
        end
    endfunction : cat_of

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        rxb_nxt = rxb_r;
        txb_nxt = txb_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_ovf_nxt = rx_ovf_r;
        rx_crc_nxt = rx_crc_r;
        tx_crc_nxt = tx_crc_r;
        tx_len_nxt = tx_len_r;
        tx_idx_nxt = tx_idx_r;
        idx_nxt = idx_r;
        no_reply_nxt = no_reply_r;
        tx_byte_nxt = tx_byte_r;
        tx_valid_nxt = tx_valid_r;
        reg_req_nxt = reg_req_r;
        reg_req_nxt.wr = 1'b0;
        reg_req_nxt.rd = 1'b0;
        case (state_r)
            ST_RECV: begin
                // collect bytes and run the checksum from the address byte on
                if (rx_valid) begin
                    if (rx_cnt_r < 6'(msg_pkg::RX_MAX)) begin
                        rxb_nxt[rx_cnt_r] = rx_byte;
                        rx_cnt_nxt = rx_cnt_r + 6'h01;
                    end else begin
                        rx_ovf_nxt = 1'b1;
                    end
                    rx_crc_nxt = rx_crc_step;
                end else if (rx_frame_end) begin
                    state_nxt = ST_CHECK;
                end
            end
            ST_CHECK: begin
                // checksum over the whole frame, its own checksum included, leaves zero
                state_nxt = ST_RECV;
                no_reply_nxt = bcast;
                tx_idx_nxt = 6'h00;
                tx_crc_nxt = msg_pkg::CRC_PRESET;
                txb_nxt[msg_pkg::POS_ADDR] = rxb_r[msg_pkg::POS_ADDR];
                txb_nxt[msg_pkg::POS_FUNC] = func;
                if ((rx_crc_r != msg_pkg::CRC_GOOD) || rx_ovf_r ||
                    (rx_cnt_r < 6'(msg_pkg::MIN_LEN)) ||
                    (!bcast && (rxb_r[msg_pkg::POS_ADDR] != station_addr))) begin
                    state_nxt = ST_RECV;
                end else if (func == msg_pkg::FC_READ) begin
                    if (!qty_ok || (rx_cnt_r != 6'(msg_pkg::FIXED_LEN))) begin
                        state_nxt = ST_SEND;
                        txb_nxt[msg_pkg::POS_FUNC] = func | msg_pkg::FC_ERR_FLAG;
                        txb_nxt[msg_pkg::POS_RCNT] = msg_pkg::EC_BAD_QTY;
                        tx_len_nxt = 6'(msg_pkg::ERR_LEN);
                    end else begin
                        state_nxt = ST_READ;
                        idx_nxt = 5'h00;
                        txb_nxt[msg_pkg::POS_RCNT] = {qty[6:0], 1'b0};
                        tx_len_nxt = 6'(msg_pkg::RD_HDR) + (qty[5:0] << 1);
                    end
                end else if (func == msg_pkg::FC_LOOP &&
                             rx_cnt_r == 6'(msg_pkg::FIXED_LEN)) begin
                    // any test code and data are echoed, checksum rebuilt identically
                    state_nxt = ST_SEND;
                    for (int i = 0; i < msg_pkg::ECHO_LEN; i++) begin
                        txb_nxt[i] = rxb_r[i];
                    end
                    tx_len_nxt = 6'(msg_pkg::ECHO_LEN);
                end else if (func == msg_pkg::FC_WRITE) begin
                    if (!qty_ok || ({8'h00, rxb_r[msg_pkg::POS_BCNT]} != (qty << 1)) ||
                        (rx_cnt_r != 6'(msg_pkg::WR_OVERHEAD) +
                                     rxb_r[msg_pkg::POS_BCNT][5:0])) begin
                        state_nxt = ST_SEND;
                        txb_nxt[msg_pkg::POS_FUNC] = func | msg_pkg::FC_ERR_FLAG;
                        txb_nxt[msg_pkg::POS_RCNT] = msg_pkg::EC_BAD_QTY;
                        tx_len_nxt = 6'(msg_pkg::ERR_LEN);
                    end else if (ro_hit) begin
                        state_nxt = ST_SEND;
                        txb_nxt[msg_pkg::POS_FUNC] = func | msg_pkg::FC_ERR_FLAG;
                        txb_nxt[msg_pkg::POS_RCNT] = msg_pkg::EC_READ_ONLY;
                        tx_len_nxt = 6'(msg_pkg::ERR_LEN);
                    end else begin
                        state_nxt = ST_WRITE;
                        idx_nxt = 5'h00;
                        for (int i = msg_pkg::POS_START_HI; i < msg_pkg::ECHO_LEN; i++) begin
                            txb_nxt[i] = rxb_r[i];
                        end
                        tx_len_nxt = 6'(msg_pkg::ECHO_LEN);
                    end
                end else begin
                    state_nxt = ST_SEND;
                    txb_nxt[msg_pkg::POS_FUNC] = func | msg_pkg::FC_ERR_FLAG;
                    txb_nxt[msg_pkg::POS_RCNT] = msg_pkg::EC_BAD_FUNC;
                    tx_len_nxt = 6'(msg_pkg::ERR_LEN);
                end
                // broadcast frames are never answered, and only writes are carried out
                if (bcast && state_nxt != ST_WRITE) begin
                    state_nxt = ST_RECV;
                end
            end
            ST_READ: begin
                // one read strobe per register, data one cycle later
                reg_req_nxt.rd = 1'b1;
                reg_req_nxt.addr = cur_addr;
                reg_req_nxt.cat = cat_of(cur_addr);
                state_nxt = ST_READ_WAIT;
            end
            ST_READ_WAIT: begin
                state_nxt = ST_READ_CAP;
            end
            ST_READ_CAP: begin
                txb_nxt[msg_pkg::RD_HDR + 2 * idx_r] = reg_rdata[15:8];
                txb_nxt[msg_pkg::RD_HDR + 2 * idx_r + 1] = reg_rdata[7:0];
                idx_nxt = idx_r + 5'h01;
                state_nxt = ({11'h000, idx_nxt} == qty) ? ST_SEND : ST_READ;
            end
            ST_WRITE: begin
                // successive words into successive registers, high byte first
                reg_req_nxt.wr = 1'b1;
                reg_req_nxt.addr = cur_addr;
                reg_req_nxt.cat = bcast ? msg_pkg::CAT_BROADCAST : cat_of(cur_addr);
                reg_req_nxt.wdata = {rxb_r[msg_pkg::POS_WDATA + 2 * idx_r],
                                     rxb_r[msg_pkg::POS_WDATA + 2 * idx_r + 1]};
                idx_nxt = idx_r + 5'h01;
                if ({11'h000, idx_nxt} == qty) begin
                    state_nxt = no_reply_r ? ST_RECV : ST_SEND;
                end
            end
            ST_SEND: begin
                // stream body, then checksum low byte and high byte
                if (!tx_valid_r || tx_ready) begin
                    if (tx_idx_r < tx_len_r) begin
                        tx_byte_nxt = load_byte;
                        tx_valid_nxt = 1'b1;
                        tx_crc_nxt = tx_crc_step;
                    end else if (tx_idx_r == tx_len_r) begin
                        tx_byte_nxt = tx_crc_r[7:0];
                        tx_valid_nxt = 1'b1;
                    end else if (tx_idx_r == tx_len_r + 6'h01) begin
                        tx_byte_nxt = tx_crc_r[15:8];
                        tx_valid_nxt = 1'b1;
                    end else begin
                        tx_valid_nxt = 1'b0;
                        state_nxt = ST_RECV;
                    end
                    tx_idx_nxt = tx_idx_r + 6'h01;
                end
            end
            default: begin
                state_nxt = ST_RECV;
            end
        endcase
        if (state_r != ST_RECV && state_nxt == ST_RECV) begin
            rx_cnt_nxt = 6'h00;
            rx_ovf_nxt = 1'b0;
            rx_crc_nxt = msg_pkg::CRC_PRESET;
        end
        // stay busy through the last write strobe of an unanswered frame
        busy_nxt = (state_nxt != ST_RECV) || reg_req_nxt.wr;
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_RECV;
            rx_cnt_r <= 6'h00;
            rx_ovf_r <= 1'b0;
            rx_crc_r <= msg_pkg::CRC_PRESET;
            tx_crc_r <= msg_pkg::CRC_PRESET;
            tx_len_r <= 6'h00;
            tx_idx_r <= 6'h00;
            idx_r <= 5'h00;
            no_reply_r <= 1'b0;
            tx_byte_r <= 8'h00;
            tx_valid_r <= 1'b0;
            reg_req_r <= '0;
            busy_r <= 1'b0;
            for (int i = 0; i < msg_pkg::RX_MAX; i++) begin
                rxb_r[i] <= 8'h00;
            end
            for (int i = 0; i < msg_pkg::TX_MAX; i++) begin
                txb_r[i] <= 8'h00;
            end
        end else begin
            state_r <= state_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_ovf_r <= rx_ovf_nxt;
            rx_crc_r <= rx_crc_nxt;
            tx_crc_r <= tx_crc_nxt;
            tx_len_r <= tx_len_nxt;
            tx_idx_r <= tx_idx_nxt;
            idx_r <= idx_nxt;
            no_reply_r <= no_reply_nxt;
            tx_byte_r <= tx_byte_nxt;
            tx_valid_r <= tx_valid_nxt;
            reg_req_r <= reg_req_nxt;
            busy_r <= busy_nxt;
            rxb_r <= rxb_nxt;
            txb_r <= txb_nxt;
        end
    end

endmodule : msg_handler
`default_nettype wire

/* hw/msg_pkg.sv */
package msg_pkg;

    // -----------------------------------------------------------------
    // function and error codes
    // -----------------------------------------------------------------
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_LOOP = 8'h08;
    localparam logic [7:0] FC_WRITE = 8'h10;
    localparam logic [7:0] FC_ERR_FLAG = 8'h80;
    localparam logic [7:0] EC_BAD_FUNC = 8'h01;
    localparam logic [7:0] EC_READ_ONLY = 8'h02;
    localparam logic [7:0] EC_BAD_QTY = 8'h03;
    localparam logic [7:0] BCAST_ADDR = 8'h00;

    // -----------------------------------------------------------------
    // checksum constants
    // -----------------------------------------------------------------
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;
    localparam int CRC_BITS = 8;

    // -----------------------------------------------------------------
    // frame sizes and byte positions
    // -----------------------------------------------------------------
    localparam int MAX_REGS = 16;
    localparam int RX_MAX = 41;
    localparam int TX_MAX = 35;
    localparam int FIXED_LEN = 8;
    localparam int WR_OVERHEAD = 9;
    localparam int MIN_LEN = 4;
    localparam int POS_ADDR = 0;
    localparam int POS_FUNC = 1;
    localparam int POS_START_HI = 2;
    localparam int POS_START_LO = 3;
    localparam int POS_QTY_HI = 4;
    localparam int POS_QTY_LO = 5;
    localparam int POS_BCNT = 6;
    localparam int POS_WDATA = 7;
    localparam int POS_RCNT = 2;
    localparam int RD_HDR = 3;
    localparam int ECHO_LEN = 6;
    localparam int ERR_LEN = 3;

    // -----------------------------------------------------------------
    // register space categories and their default boundaries
    // -----------------------------------------------------------------
    localparam logic [15:0] MONITOR_BASE = 16'h0020;
    localparam logic [15:0] BCAST_BASE = 16'h0100;

    typedef enum logic [1:0] {
        CAT_COMMAND,
        CAT_MONITOR,
        CAT_BROADCAST
    } reg_cat_t;

    typedef struct packed {
        logic wr;
        logic rd;
        reg_cat_t cat;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

endpackage : msg_pkg

/* sim/msg_handler_checker.sv */
`timescale 1ns/1ns
`default_nettype none

module msg_handler_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // transmit side
    input wire logic [7:0] tx_byte_r,
    input wire logic tx_valid_r,
    input wire logic tx_ready,
    // register side and status
    input wire msg_pkg::reg_req_t reg_req_r,
    input wire logic busy_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // -----------------------------------------------------------------
    // sequences
    // -----------------------------------------------------------------
    sequence rd_gap;
        !reg_req_r.rd ##1 !reg_req_r.rd;
    endsequence
    sequence tx_stall;
        tx_valid_r && !tx_ready;
    endsequence

    // -----------------------------------------------------------------
    // properties
    // -----------------------------------------------------------------
    chk_tx_hold: assert property (tx_stall |=> tx_valid_r && $stable(tx_byte_r))
        else $error("stalled tx byte changed");
    chk_rd_space: assert property (reg_req_r.rd |=> rd_gap)
        else $error("read strobes too close");
    chk_rd_ascend: assert property (reg_req_r.rd ##3 reg_req_r.rd |->
        reg_req_r.addr == $past(reg_req_r.addr, 3) + 16'h0001)
        else $error("read addresses not ascending");
    chk_wr_ascend: assert property (reg_req_r.wr && $past(reg_req_r.wr) |->
        reg_req_r.addr == $past(reg_req_r.addr) + 16'h0001)
        else $error("write addresses not ascending");
    chk_idle_quiet: assert property (!busy_r |-> !tx_valid_r && !reg_req_r.wr)
        else $error("activity while idle");
    chk_no_mon_wr: assert property (
        reg_req_r.wr |-> reg_req_r.cat != msg_pkg::CAT_MONITOR)
        else $error("write into monitor space");
    chk_cat_cmd: assert property (
        reg_req_r.wr && reg_req_r.cat == msg_pkg::CAT_COMMAND |->
        reg_req_r.addr < msg_pkg::MONITOR_BASE)
        else $error("command category outside command space");
    chk_rd_wr_excl: assert property (reg_req_r.rd |-> !reg_req_r.wr)
        else $error("read and write together");
    cov_wr_pair: cover property (reg_req_r.wr ##1 reg_req_r.wr);
endmodule : msg_handler_checker

`default_nettype wire

/* sim/msg_handler_test.sv */
`timescale 1ns/1ns
`default_nettype none

module msg_handler_test;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] station_addr = 8'h01;
    logic [7:0] rx_byte = 8'h00;
    logic rx_valid = 1'b0;
    logic rx_frame_end = 1'b0;
    logic [7:0] tx_byte_r;
    logic tx_valid_r;
    logic tx_ready;
    logic busy_r;
    msg_pkg::reg_req_t reg_req_r;
    logic [15:0] reg_rdata;
    int err_count = 0;
    int compares = 0;
    logic [7:0] txq[$];
    logic [31:0] wrq[$];
    logic [15:0] mirror [0:511];
    logic [7:0] fr[$];

    always #50 sys_clk = ~sys_clk;

    msg_handler u_msg_handler (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .station_addr(station_addr), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_frame_end(rx_frame_end), .tx_byte_r(tx_byte_r), .tx_valid_r(tx_valid_r),
        .tx_ready(tx_ready), .reg_req_r(reg_req_r), .reg_rdata(reg_rdata), .busy_r(busy_r));
    reg_table_model u_reg_table_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_req_r(reg_req_r), .reg_rdata(reg_rdata), .tx_ready(tx_ready));

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction : crc16

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // expected reply: body, checksum low then high
    task automatic reply(input logic [7:0] r[$]);
        logic [15:0] c;
        c = crc16(r);
        foreach (r[i]) txq.push_back(r[i]);
        txq.push_back(c[7:0]);
        txq.push_back(c[15:8]);
    endtask : reply

    // one frame in, with a good or spoiled checksum, then the gap pulse
    task automatic send(input logic [7:0] q[$], input bit good);
        logic [15:0] c;
        c = crc16(q) ^ (good ? 16'h0000 : 16'h0001);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            @(posedge sys_clk);
            rx_byte <= q[i];
            rx_valid <= 1'b1;
        end
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        rx_frame_end <= 1'b1;
        @(posedge sys_clk);
        rx_frame_end <= 1'b0;
    endtask : send

    task automatic finish_test(input string name);
        int n;
        n = 0;
        repeat (3) @(posedge sys_clk);
        while (busy_r !== 1'b0 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (2) @(posedge sys_clk);
        check(32'(txq.size()), 32'h00000000);
        check(32'(wrq.size()), 32'h00000000);
        check({31'h0, busy_r}, 32'h00000000);
        $display("test %s done", name);
    endtask : finish_test

    task automatic do_read(input logic [7:0] a, input logic [15:0] s, input logic [15:0] n);
        logic [7:0] r[$];
        r = {a, 8'h03, 8'(2 * n)};
        for (int i = 0; i < n; i++) r = {r, mirror[s + 16'(i)][15:8], mirror[s + 16'(i)][7:0]};
        if (n == 16'h0000 || n > 16'h0010) r = {a, 8'h83, 8'h03};
        reply(r);
        send({a, 8'h03, s[15:8], s[7:0], n[15:8], n[7:0]}, 1'b1);
        finish_test("read");
    endtask : do_read

    task automatic do_write(input logic [7:0] a, input logic [15:0] s, input int n,
        input logic [7:0] bc);
        logic [7:0] q[$];
        logic [15:0] w;
        bit ok;
        ok = (bc == 8'(2 * n)) && (s + 16'(n) <= 16'h0020);
        q = {a, 8'h10, s[15:8], s[7:0], 8'h00, 8'(n), bc};
        fr = {a, 8'h10, s[15:8], s[7:0], 8'h00, 8'(n)};
        for (int i = 0; i < n; i++) begin
            w = 16'($urandom);
            q = {q, w[15:8], w[7:0]};
            if (ok) wrq.push_back({s + 16'(i), w});
            if (ok) mirror[s + 16'(i)] = w;
        end
        if (!ok) fr = {a, 8'h90, (bc != 8'(2 * n)) ? 8'h03 : 8'h02};
        if (a != 8'h00) reply(fr);
        send(q, 1'b1);
        finish_test("write");
    endtask : do_write

    // -----------------------------------------------------------------
    // output monitor: every taken byte and every write against the notes
    // -----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (sys_rst === 1'b0 && tx_valid_r === 1'b1 && tx_ready === 1'b1) begin
            if (txq.size() == 0) check({24'h0, tx_byte_r}, 32'h00000100);
            else check({24'h0, tx_byte_r}, {24'h0, txq.pop_front()});
        end
        if (sys_rst === 1'b0 && reg_req_r.wr === 1'b1) begin
            if (wrq.size() == 0) check({reg_req_r.addr, reg_req_r.wdata}, 32'hFFFFFFFF);
            else check({reg_req_r.addr, reg_req_r.wdata}, wrq.pop_front());
        end
    end

    initial begin
        #3000000;
        err_count++;
        final_report();
    end

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        void'($urandom(96758));
        for (int i = 0; i < 512; i++) mirror[i] = 16'h3C00 ^ 16'(i);
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        check(32'(crc16({8'h02, 8'h03})), 32'h0000D140);
        // loopback with the sample frame, then arbitrary codes and data
        for (int t = 0; t < 5; t++) begin
            fr = {8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37};
            if (t > 0) fr = {8'h01, 8'h08, 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
            reply(fr);
            send(fr, 1'b1);
            finish_test("loopback");
        end
        // spoiled checksum and foreign station: silence
        send({8'h01, 8'h08, 8'h12, 8'h34, 8'h56, 8'h78}, 1'b0);
        finish_test("bad checksum");
        send({8'h05, 8'h08, 8'h12, 8'h34, 8'h56, 8'h78}, 1'b1);
        finish_test("foreign station");
        // unknown function
        fr = {8'h01, 8'h85, 8'h01};
        reply(fr);
        send({8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1);
        finish_test("bad function");
        // reads: sample request, full sixteen, too many, none
        @(posedge sys_clk);
        station_addr <= 8'h02;
        @(posedge sys_clk);
        do_read(8'h02, 16'h0020, 16'h0004);
        do_read(8'h02, 16'h0000, 16'h0010);
        do_read(8'h02, 16'h0000, 16'h0011);
        do_read(8'h02, 16'h0003, 16'h0000);
        // writes: normal, byte count wrong, touching monitor space, broadcast
        do_write(8'h02, 16'h0001, 2, 8'h04);
        do_read(8'h02, 16'h0001, 16'h0002);
        do_write(8'h02, 16'h0004, 16, 8'h20);
        do_write(8'h02, 16'h0004, 3, 8'h05);
        do_write(8'h02, 16'h001F, 2, 8'h04);
        do_write(8'h00, 16'h0008, 3, 8'h06);
        do_read(8'h02, 16'h0008, 16'h0003);
        // broadcast read: no register access result, no reply
        send({8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b1);
        finish_test("broadcast read");
        final_report();
    end
endmodule : msg_handler_test

bind msg_handler msg_handler_checker u_msg_handler_checker (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .tx_byte_r(tx_byte_r), .tx_valid_r(tx_valid_r),
    .tx_ready(tx_ready), .reg_req_r(reg_req_r), .busy_r(busy_r));

`default_nettype wire

/* sim/reg_table_model.sv */
`timescale 1ns/1ns
`default_nettype none

module reg_table_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register access from the handler
    input wire msg_pkg::reg_req_t reg_req_r,
    output logic [15:0] reg_rdata,
    // transmit pacing
    output logic tx_ready
);
    logic [15:0] mem [0:511];

    // table preset to a known pattern of two-byte words
    initial begin
        for (int i = 0; i < 512; i++) mem[i] = 16'h3C00 ^ 16'(i);
    end

    // read data one cycle after the strobe, a moving pattern otherwise; random stalls
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
            tx_ready <= 1'b0;
        end else begin
            reg_rdata <= reg_req_r.rd ? mem[reg_req_r.addr[8:0]] : ~reg_rdata;
            tx_ready <= ($urandom % 4) != 0;
            // written values take effect at once, as with no enter command required
            if (reg_req_r.wr) mem[reg_req_r.addr[8:0]] <= reg_req_r.wdata;
        end
    end
endmodule : reg_table_model

`default_nettype wire
